// ### core/txq_free_cache.sv
`timescale 1ns/10ps
module txq_free_cache (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [txq_pkg::RET_W-1:0] push_data,
   output logic in_ready,
   input wire logic pop,
   output logic out_valid,
   output logic [txq_pkg::RET_W-1:0] out_data,
   output logic [txq_pkg::CNT_W-1:0] count
);
   import txq_pkg::*;

   typedef struct packed {
      logic [CACHE_DEPTH-1:0][RET_W-1:0] slot;
      logic [CNT_W-1:0] rp;
      logic [CNT_W-1:0] wp;
      logic [CNT_W-1:0] cnt;
   } txq_cache_s;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(CACHE_DEPTH - 1);
   localparam logic [CNT_W-1:0] DEPTH = CNT_W'(CACHE_DEPTH);

   txq_cache_s s;
   txq_cache_s nx;
   logic push_ok;
   logic pop_ok;

   assign in_ready = (s.cnt != DEPTH);
   assign out_valid = (s.cnt != 3'h0);
   assign out_data = s.slot[s.rp];
   assign count = s.cnt;

   always_comb begin
      nx = s;
      push_ok = push && in_ready;
      pop_ok = pop && out_valid;
      if (push_ok) begin
         nx.slot[s.wp] = push_data;
         nx.wp = (s.wp == LAST) ? 3'h0 : s.wp + 3'h1;
      end
      if (pop_ok) begin
         nx.rp = (s.rp == LAST) ? 3'h0 : s.rp + 3'h1;
      end
      nx.cnt = s.cnt + {2'h0, push_ok} - {2'h0, pop_ok};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= nx;
      end
   end

   cache_cap_a: assert property (@(posedge clk) disable iff (rst)
      (s.cnt == DEPTH && push && !pop) |=> (s.cnt == DEPTH))
      else $error("free cache overfilled");
endmodule

// ### core/txq_manager.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Function
// - link fetched descriptors into per-channel, per-priority lists by engine link
// - unprovisioned channel: return list head on free ring, status unprovisioned
// - continuation 1 means more pieces follow; 0 means whole or last piece
// - follow host links until a descriptor marked chain-end
// - buffer size field is never used
// - descriptor address is table base plus sixteen times reference
// - references arrive on ready ring and go back on free ring
// - six-entry free cache; when enabled, each ring write waits until all six entries are held
// - completion-flagged descriptor flushes cache and goes straight to ring
// - writing one to free_cache_flush flushes; the bit clears itself
// - rings located by one shared base and eight 16-bit indices
// - read index marks last read slot; write index marks next free slot
// - slot at end index is never used; valid slots start to end minus one
// - empty when read is write minus one, or end minus one with write at start
// - full when read index equals write index
// - ring element low 18 bits: 15-bit reference and three status bits
// - free ring writes zero bits 23:18 and leave 31:24 untouched
// - no access to a descriptor or buffer after its return
// - status 00 last, 01 partial, 10 unprovisioned, 11 malformed
// - status bit two reports underflow
// - completion interrupt when a completion-flagged buffer has been read
module txq_manager (
   input wire logic clk,
   input wire logic rst,
   input wire logic [txq_pkg::REG_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_be,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic svc_req,
   input wire logic [txq_pkg::LIST_W-1:0] svc_list,
   input wire logic svc_underflow,
   input wire logic unprov_req,
   input wire logic [txq_pkg::LIST_W-1:0] unprov_list,
   output logic cmd_ready,
   output logic completion_interrupt
);
   import txq_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_RING_RD = 4'h1,
      S_DESC_RD1 = 4'h2,
      S_DESC_RD2 = 4'h3,
      S_LINK_WR = 4'h4,
      S_SVC_RD1 = 4'h5,
      S_SVC_RD3 = 4'h6,
      S_RET = 4'h7,
      S_FREE_WR = 4'h8
   } txq_state_e;

   typedef struct packed {
      txq_state_e st;
      txq_state_e back;
      logic [31:0] desc_base;
      logic [31:0] ring_base;
      logic [NUM_IDX-1:0][IDX_W-1:0] idx;
      logic [2:0] ctl;
      logic [REF_W-1:0] ref_cur;
      logic [REF_W-1:0] nxt;
      logic [LIST_W-1:0] list;
      logic [31:0] w1;
      logic [RET_W-1:0] ret;
      logic ret_ioc;
      logic cont;
      logic under;
      logic irq;
      logic [31:0] rdata;
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } txq_main_s;

   txq_main_s s;
   txq_main_s nx;

   logic [REF_W-1:0] head_mem [TBL_SIZE];
   logic [REF_W-1:0] tail_mem [TBL_SIZE];
   logic [TBL_SIZE-1:0] lvalid;
   logic [LIST_W-1:0] look_idx;
   logic [REF_W-1:0] t_head;
   logic [REF_W-1:0] t_tail;
   logic t_valid;
   logic tbl_we;
   logic [REF_W-1:0] tbl_h;
   logic [REF_W-1:0] tbl_t;
   logic tbl_v;

   logic rq_empty;
   logic fq_full;
   logic [IDX_W-1:0] rq_next;
   logic [IDX_W-1:0] fq_next;
   logic push;
   logic pop;
   logic c_ready;
   logic c_valid;
   logic [RET_W-1:0] c_data;
   logic [CNT_W-1:0] c_cnt;
   logic drain_go;
   logic bad;
   logic [3:0] dec;

   function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [REF_W-1:0] r,
                                             input logic [3:0] w);
      return (base & DESC_BASE_MASK) + (32'(r) << DESC_SHIFT) + 32'(w);
   endfunction

   function automatic logic [31:0] ring_addr(input logic [31:0] base, input logic [IDX_W-1:0] i);
      return (base & RING_BASE_MASK) + (32'(i) << RING_SHIFT);
   endfunction

   // returns {hit, slot} for the index register window
   function automatic logic [3:0] idx_dec(input logic [REG_AW-1:0] a);
      logic [REG_AW-1:0] d;
      d = a - A_IDX0;
      return {(a >= A_IDX0) && (a <= A_IDX_LAST) && (a[1:0] == 2'h0), d[4:2]};
   endfunction

   txq_ring_calc u_ready_ring (
      .start_idx(s.idx[I_RS]),
      .stop_idx(s.idx[I_RE]),
      .rd_idx(s.idx[I_RR]),
      .wr_idx(s.idx[I_RW]),
      .empty(rq_empty),
      .full(),
      .rd_next(rq_next),
      .wr_next()
   );

   txq_ring_calc u_free_ring (
      .start_idx(s.idx[I_FS]),
      .stop_idx(s.idx[I_FE]),
      .rd_idx(s.idx[I_FR]),
      .wr_idx(s.idx[I_FW]),
      .empty(),
      .full(fq_full),
      .rd_next(),
      .wr_next(fq_next)
   );

   txq_free_cache u_cache (
      .clk(clk),
      .rst(rst),
      .push(push),
      .push_data(s.ret),
      .in_ready(c_ready),
      .pop(pop),
      .out_valid(c_valid),
      .out_data(c_data),
      .count(c_cnt)
   );

   always_comb begin
      unique case (s.st)
         S_IDLE: look_idx = svc_req ? svc_list : unprov_list;
         S_DESC_RD2: look_idx = {s.w1[F_TCC +: 10], s.w1[F_P]};
         default: look_idx = s.list;
      endcase
   end

   assign t_head = head_mem[look_idx];
   assign t_tail = tail_mem[look_idx];
   assign t_valid = lvalid[look_idx];
   assign bad = (s.w1[F_BYTES +: 16] == 16'h0000) || (s.w1[F_M] && s.w1[F_CE]);
   assign drain_go = c_valid && !fq_full &&
                     (s.ctl[CTL_FLUSH] || !s.ctl[CTL_CACHE] || c_cnt == CNT_W'(CACHE_DEPTH));
   assign cmd_ready = (s.st == S_IDLE) && !drain_go;
   assign dec = idx_dec(reg_addr);

   always_comb begin
      nx = s;
      nx.irq = 1'b0;
      nx.rdata = 32'h00000000;
      push = 1'b0;
      pop = 1'b0;
      tbl_we = 1'b0;
      tbl_h = t_head;
      tbl_t = t_tail;
      tbl_v = t_valid;
      if (s.ctl[CTL_FLUSH] && !c_valid) begin
         nx.ctl[CTL_FLUSH] = 1'b0;
      end
      if (reg_wr) begin
         if (reg_addr == A_DESC_BASE) begin
            nx.desc_base = reg_wdata;
         end else if (reg_addr == A_RING_BASE) begin
            nx.ring_base = reg_wdata;
         end else if (reg_addr == A_CTL) begin
            nx.ctl[CTL_CACHE] = reg_wdata[CTL_CACHE];
            nx.ctl[CTL_FETCH] = reg_wdata[CTL_FETCH];
            if (reg_wdata[CTL_FLUSH]) begin
               nx.ctl[CTL_FLUSH] = 1'b1;
            end
         end else if (dec[3]) begin
            nx.idx[dec[2:0]] = reg_wdata[IDX_W-1:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == A_DESC_BASE) begin
            nx.rdata = s.desc_base;
         end else if (reg_addr == A_RING_BASE) begin
            nx.rdata = s.ring_base;
         end else if (reg_addr == A_CTL) begin
            nx.rdata = {29'h0, s.ctl};
         end else if (reg_addr == A_STAT) begin
            nx.rdata = {23'h0, c_cnt, fq_full, rq_empty, s.st};
         end else if (dec[3]) begin
            nx.rdata = {16'h0000, s.idx[dec[2:0]]};
         end
      end
      unique case (s.st)
         S_IDLE: begin
            if (drain_go) begin
               nx.back = S_IDLE;
               nx.st = S_FREE_WR;
            end else if (svc_req && t_valid) begin
               nx.list = svc_list;
               nx.ref_cur = t_head;
               nx.under = svc_underflow;
               nx.st = S_SVC_RD1;
            end else if (unprov_req && t_valid) begin
               nx.list = unprov_list;
               nx.ret = {1'b0, ST_UNPROV, t_head};
               nx.ret_ioc = 1'b0;
               nx.cont = 1'b0;
               tbl_we = 1'b1;
               tbl_v = 1'b0;
               nx.st = S_RET;
            end else if (s.ctl[CTL_FETCH] && !rq_empty) begin
               nx.st = S_RING_RD;
            end
         end
         S_RING_RD: begin
            if (mem_ack) begin
               nx.ref_cur = mem_rdata[REF_W-1:0];
               nx.idx[I_RR] = rq_next;
               nx.st = S_DESC_RD1;
            end
         end
         S_DESC_RD1: begin
            if (mem_ack) begin
               nx.w1 = mem_rdata;
               nx.st = S_DESC_RD2;
            end
         end
         S_DESC_RD2: begin
            if (mem_ack) begin
               // only the host link half of this word is kept; the size half is dropped
               nx.nxt = mem_rdata[REF_W-1:0];
               nx.cont = !s.w1[F_CE];
               nx.list = look_idx;
               if (bad) begin
                  nx.ret = {1'b0, ST_BAD, s.ref_cur};
                  nx.ret_ioc = 1'b0;
                  nx.st = S_RET;
               end else if (t_valid) begin
                  nx.st = S_LINK_WR;
               end else begin
                  tbl_we = 1'b1;
                  tbl_h = s.ref_cur;
                  tbl_t = s.ref_cur;
                  tbl_v = 1'b1;
                  nx.ref_cur = nx.cont ? nx.nxt : s.ref_cur;
                  nx.st = nx.cont ? S_DESC_RD1 : S_IDLE;
               end
            end
         end
         S_LINK_WR: begin
            if (mem_ack) begin
               tbl_we = 1'b1;
               tbl_t = s.ref_cur;
               nx.ref_cur = s.cont ? s.nxt : s.ref_cur;
               nx.st = s.cont ? S_DESC_RD1 : S_IDLE;
            end
         end
         S_SVC_RD1: begin
            if (mem_ack) begin
               nx.w1 = mem_rdata;
               nx.st = S_SVC_RD3;
            end
         end
         S_SVC_RD3: begin
            if (mem_ack) begin
               tbl_we = 1'b1;
               tbl_h = mem_rdata[REF_W-1:0];
               tbl_v = mem_rdata[F_V];
               nx.ret = {s.under, s.w1[F_M] ? ST_PART : ST_LAST, s.ref_cur};
               nx.ret_ioc = s.w1[F_IOC];
               nx.irq = s.w1[F_IOC];
               nx.cont = 1'b0;
               nx.st = S_RET;
            end
         end
         S_RET: begin
            if (c_ready) begin
               push = 1'b1;
               if (s.ret_ioc) begin
                  nx.ctl[CTL_FLUSH] = 1'b1;
               end
               nx.ref_cur = s.cont ? s.nxt : s.ref_cur;
               nx.st = s.cont ? S_DESC_RD1 : S_IDLE;
            end else if (drain_go) begin
               nx.back = S_RET;
               nx.st = S_FREE_WR;
            end
         end
         S_FREE_WR: begin
            if (mem_ack) begin
               pop = 1'b1;
               nx.idx[I_FW] = fq_next;
               nx.st = s.back;
            end
         end
      endcase
      nx.req = 1'b0;
      nx.we = 1'b0;
      nx.be = FULL_BE;
      nx.addr = 32'h00000000;
      nx.wdata = 32'h00000000;
      unique case (nx.st)
         S_IDLE, S_RET: begin
         end
         S_RING_RD: begin
            nx.req = 1'b1;
            nx.addr = ring_addr(nx.ring_base, rq_next);
         end
         S_DESC_RD1, S_SVC_RD1: begin
            nx.req = 1'b1;
            nx.addr = desc_addr(nx.desc_base, nx.ref_cur, W1_OFS);
         end
         S_DESC_RD2: begin
            nx.req = 1'b1;
            nx.addr = desc_addr(nx.desc_base, nx.ref_cur, W2_OFS);
         end
         S_SVC_RD3: begin
            nx.req = 1'b1;
            nx.addr = desc_addr(nx.desc_base, nx.ref_cur, W3_OFS);
         end
         S_LINK_WR: begin
            nx.req = 1'b1;
            nx.we = 1'b1;
            nx.addr = desc_addr(nx.desc_base, t_tail, W3_OFS);
            nx.wdata = {16'h0000, 1'b1, nx.ref_cur};
         end
         S_FREE_WR: begin
            nx.req = 1'b1;
            nx.we = 1'b1;
            nx.be = FREE_BE;
            nx.addr = ring_addr(nx.ring_base, nx.idx[I_FW]);
            nx.wdata = {14'h0000, c_data};
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.ctl <= CTL_RST;
      end else begin
         s <= nx;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lvalid <= '0;
      end else if (tbl_we) begin
         lvalid[look_idx] <= tbl_v;
      end
   end

   always_ff @(posedge clk) begin
      if (tbl_we) begin
         head_mem[look_idx] <= tbl_h;
         tail_mem[look_idx] <= tbl_t;
      end
   end

   assign reg_rdata = s.rdata;
   assign mem_req = s.req;
   assign mem_we = s.we;
   assign mem_addr = s.addr;
   assign mem_wdata = s.wdata;
   assign mem_be = s.be;
   assign completion_interrupt = s.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence ioc_read_s;
      s.st == S_SVC_RD3 && mem_ack && s.w1[F_IOC];
   endsequence
   sequence irq_pulse_s;
      completion_interrupt ##1 !completion_interrupt;
   endsequence
   sequence unprov_take_s;
      cmd_ready && !svc_req && unprov_req && t_valid;
   endsequence

   irq_on_read_a: assert property (ioc_read_s |=> irq_pulse_s)
      else $error("completion interrupt missing");
   ioc_flush_a: assert property (ioc_read_s ##1 (s.st == S_RET && c_ready) |=> s.ctl[CTL_FLUSH])
      else $error("completion did not start a flush");
   unprov_ret_a: assert property (unprov_take_s |=> s.st == S_RET && s.ret[16:15] == ST_UNPROV)
      else $error("unprovisioned head not returned");
   free_lanes_a: assert property (mem_req && s.st == S_FREE_WR |-> mem_be == 4'h7 && mem_wdata[23:18] == 6'h00)
      else $error("free ring write lanes wrong");
   free_room_a: assert property (s.st != S_FREE_WR ##1 s.st == S_FREE_WR |-> !$past(fq_full))
      else $error("free write started on full ring");
   ready_avail_a: assert property (s.st == S_IDLE ##1 s.st == S_RING_RD |-> !$past(rq_empty))
      else $error("ready fetch on empty ring");
   group_six_a: assert property (s.st == S_IDLE && nx.st == S_FREE_WR |->
      c_cnt == 3'h6 || !s.ctl[CTL_CACHE] || s.ctl[CTL_FLUSH])
      else $error("free write before group complete");
   desc_addr_a: assert property (mem_req && s.st == S_DESC_RD1 |->
      mem_addr == (s.desc_base & 32'hFFFFFFF0) + {13'h0, s.ref_cur, 4'h4})
      else $error("descriptor address wrong");
   chain_follow_a: assert property (s.st == S_LINK_WR && mem_ack && s.cont |=> s.st == S_DESC_RD1 &&
      s.ref_cur == $past(s.nxt))
      else $error("host link not followed");
   bad_ret_a: assert property (s.st == S_DESC_RD2 && mem_ack && bad |=> s.ret[16:15] == ST_BAD)
      else $error("malformed descriptor not flagged");
endmodule

// ### core/txq_ring_calc.sv
`timescale 1ns/10ps
module txq_ring_calc (
   input wire logic [txq_pkg::IDX_W-1:0] start_idx,
   input wire logic [txq_pkg::IDX_W-1:0] stop_idx,
   input wire logic [txq_pkg::IDX_W-1:0] rd_idx,
   input wire logic [txq_pkg::IDX_W-1:0] wr_idx,
   output logic empty,
   output logic full,
   output logic [txq_pkg::IDX_W-1:0] rd_next,
   output logic [txq_pkg::IDX_W-1:0] wr_next
);
   import txq_pkg::*;

   // the slot at the stop index is skipped: wrap to start
   function automatic logic [IDX_W-1:0] step(input logic [IDX_W-1:0] x, input logic [IDX_W-1:0] st,
                                             input logic [IDX_W-1:0] sp);
      logic [IDX_W-1:0] inc;
      inc = x + 16'h0001;
      return (inc == sp) ? st : inc;
   endfunction

   always_comb begin
      empty = (rd_idx == wr_idx - 16'h0001) ||
              ((rd_idx == stop_idx - 16'h0001) && (wr_idx == start_idx));
      full = (rd_idx == wr_idx);
      rd_next = step(rd_idx, start_idx, stop_idx);
      wr_next = step(wr_idx, start_idx, stop_idx);
   end
endmodule

// ### inc/txq_pkg.sv
package txq_pkg;
   localparam int REF_W = 15;
   localparam int IDX_W = 16;
   localparam int RET_W = 18;
   localparam int LIST_W = 11;
   localparam int TBL_SIZE = 2048;
   localparam int CACHE_DEPTH = 6;
   localparam int CNT_W = 3;
   localparam int REG_AW = 6;
   // register byte offsets
   localparam logic [5:0] A_DESC_BASE = 6'h00;
   localparam logic [5:0] A_RING_BASE = 6'h04;
   localparam logic [5:0] A_IDX0 = 6'h08;
   localparam logic [5:0] A_IDX_LAST = 6'h24;
   localparam logic [5:0] A_CTL = 6'h28;
   localparam logic [5:0] A_STAT = 6'h2C;
   // index register slots, in address order from A_IDX0
   localparam int I_RS = 0;
   localparam int I_RW = 1;
   localparam int I_RR = 2;
   localparam int I_RE = 3;
   localparam int I_FS = 4;
   localparam int I_FW = 5;
   localparam int I_FR = 6;
   localparam int I_FE = 7;
   localparam int NUM_IDX = 8;
   // control bits
   localparam int CTL_CACHE = 0;
   localparam int CTL_FLUSH = 1;
   localparam int CTL_FETCH = 2;
   localparam logic [2:0] CTL_RST = 3'h1;
   // address forming
   localparam logic [31:0] DESC_BASE_MASK = 32'hFFFFFFF0;
   localparam logic [31:0] RING_BASE_MASK = 32'hFFFFFFFC;
   localparam int DESC_SHIFT = 4;
   localparam int RING_SHIFT = 2;
   localparam logic [3:0] W1_OFS = 4'h4;
   localparam logic [3:0] W2_OFS = 4'h8;
   localparam logic [3:0] W3_OFS = 4'hC;
   // descriptor word 1 fields
   localparam int F_BYTES = 0;
   localparam int F_TCC = 16;
   localparam int F_P = 26;
   localparam int F_IOC = 28;
   localparam int F_CE = 29;
   localparam int F_M = 30;
   // descriptor word 3: engine link valid
   localparam int F_V = 15;
   // returned status codes
   localparam logic [1:0] ST_LAST = 2'h0;
   localparam logic [1:0] ST_PART = 2'h1;
   localparam logic [1:0] ST_UNPROV = 2'h2;
   localparam logic [1:0] ST_BAD = 2'h3;
   localparam logic [3:0] FREE_BE = 4'h7;
   localparam logic [3:0] FULL_BE = 4'hF;
endpackage

// ### tb/txq_host_mem.sv
`timescale 1ns/10ps
module txq_host_mem (
   input wire logic clk,
   input wire logic rst,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [3:0] mem_be,
   input wire logic [1:0] slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [int unsigned];
   logic [1:0] wait_reg;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_reg <= 2'h0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack <= 1'b0;
         // data lines do not hold their value outside an answer
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            if (wait_reg < slow) begin
               wait_reg <= wait_reg + 2'h1;
            end else begin
               wait_reg <= 2'h0;
               mem_ack <= 1'b1;
               if (!mem_we) begin
                  mem_rdata <= mem[mem_addr];
               end else begin
                  // unenabled bytes keep what software left there
                  for (int b = 0; b < 4; b++) begin
                     if (mem_be[b]) mem[mem_addr][8*b+:8] <= mem_wdata[8*b+:8];
                  end
               end
            end
         end
      end
   end
endmodule

// ### tb/txq_manager_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module txq_manager_tb;
   import txq_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [REG_AW-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, mem_req, mem_we, mem_ack, cmd_ready, completion_interrupt;
   logic [3:0] mem_be;
   logic svc_req = 1'b0, svc_underflow = 1'b0, unprov_req = 1'b0, returned = 1'b0;
   logic [LIST_W-1:0] svc_list = '0, unprov_list = '0;
   logic [1:0] slow = 2'h0;
   int mismatches = 0, samples_checked = 0, irq_cnt = 0, cycles = 0;
   logic [31:0] exp_q [$];
   always #50 clk = ~clk;
   txq_manager txq_manager_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .svc_req(svc_req), .svc_list(svc_list), .svc_underflow(svc_underflow), .unprov_req(unprov_req),
      .unprov_list(unprov_list), .cmd_ready(cmd_ready), .completion_interrupt(completion_interrupt));
   txq_host_mem txq_host_mem_i (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_be(mem_be), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   always @(posedge clk) begin
      cycles++;
      if (completion_interrupt === 1'b1) irq_cnt++;
      if (returned && mem_req === 1'b1) `CHK(mem_addr[31:4] === 28'h109, 1'b0)
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic reg_wr_t(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_rd_t(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic settle();
      int quiet;
      quiet = 0;
      for (int n = 0; n < 3000 && quiet < 20; n++) begin
         @(posedge clk);
         quiet = (mem_req === 1'b1) ? 0 : quiet + 1;
      end
   endtask
   // one service or unprovision command, held until the design takes it
   task automatic cmd(input logic svc, input logic [LIST_W-1:0] lst, input logic uf);
      @(posedge clk);
      slow <= 2'($urandom_range(2));
      svc_req <= svc;
      unprov_req <= !svc;
      svc_list <= lst;
      unprov_list <= lst;
      svc_underflow <= uf;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         if (cmd_ready === 1'b1) break;
      end
      @(posedge clk);
      svc_req <= 1'b0;
      unprov_req <= 1'b0;
      settle();
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      logic [31:0] rd;
      int idx_v [8] = '{0, 2, 7, 8, 16, 16, 23, 24};
      void'($urandom(12715));
      for (int a = 32'h1000; a < 32'h10A0; a += 4) txq_host_mem_i.mem[a] = 32'h0;
      txq_host_mem_i.mem[32'h1034] = 32'h4005_0040;
      txq_host_mem_i.mem[32'h1038] = {16'($urandom), 16'h0004};
      txq_host_mem_i.mem[32'h1044] = 32'h3005_0020;
      txq_host_mem_i.mem[32'h1048] = {16'($urandom), 16'h0000};
      txq_host_mem_i.mem[32'h1094] = 32'h2406_0008;
      txq_host_mem_i.mem[32'h8000] = 32'h3;
      txq_host_mem_i.mem[32'h8004] = 32'h9;
      for (int i = 0; i < 4; i++) txq_host_mem_i.mem[32'h8040 + 4 * i] = 32'hA5A5_A5A5;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      reg_rd_t(A_CTL, rd);
      `CHK(rd[2:0], CTL_RST)
      reg_wr_t(6'h30, 32'hFFFF_FFFF);
      reg_rd_t(6'h30, rd);
      `CHK(rd, 32'h0)
      reg_wr_t(A_DESC_BASE, 32'h0000_100F);
      reg_wr_t(A_RING_BASE, 32'h0000_8003);
      for (int i = 0; i < NUM_IDX; i++) reg_wr_t(A_IDX0 + 6'(4 * i), 32'(idx_v[i]));
      reg_rd_t(A_IDX_LAST, rd);
      `CHK(rd, 32'd24)
      $display("test registers done");
      reg_wr_t(A_CTL, 32'h5);
      settle();
      reg_rd_t(A_IDX0 + 6'(4 * I_RR), rd);
      `CHK(rd, 32'h1)
      reg_rd_t(A_STAT, rd);
      `CHK(rd[4], 1'b1)
      `CHK(txq_host_mem_i.mem[32'h103C], 32'h0000_8004)
      $display("test fetch done");
      cmd(1'b1, 11'd10, 1'b1);
      exp_q.push_back({8'hA5, 6'h0, 1'b1, ST_PART, 15'd3});
      reg_rd_t(A_STAT, rd);
      `CHK(rd[8:6], 3'h1)
      reg_rd_t(A_IDX0 + 6'(4 * I_FW), rd);
      `CHK(rd, 32'd16)
      cmd(1'b0, 11'd13, 1'b0);
      returned = 1'b1;
      exp_q.push_back({8'hA5, 6'h0, 1'b0, ST_UNPROV, 15'd9});
      cmd(1'b1, 11'd10, 1'b0);
      exp_q.push_back({8'hA5, 6'h0, 1'b0, ST_LAST, 15'd4});
      `CHK(irq_cnt, 1)
      for (int i = 0; i < 4; i++) begin
         if (i < 3) `CHK(txq_host_mem_i.mem[32'h8040 + 4 * i], exp_q[i])
         else `CHK(txq_host_mem_i.mem[32'h8040 + 4 * i], 32'hA5A5_A5A5)
      end
      reg_rd_t(A_IDX0 + 6'(4 * I_FW), rd);
      `CHK(rd, 32'd19)
      $display("test returns done");
      reg_wr_t(A_CTL, 32'h7);
      reg_rd_t(A_CTL, rd);
      `CHK(rd[2:0], 3'h5)
      $display("test flush done");
      // malformed head, then a host chain that starts an emptied list and is linked onto it
      txq_host_mem_i.mem[32'h8008] = 32'h5;
      txq_host_mem_i.mem[32'h1054] = 32'h0005_0000;
      txq_host_mem_i.mem[32'h1058] = {16'($urandom), 16'h0006};
      txq_host_mem_i.mem[32'h1064] = 32'h4005_0010;
      txq_host_mem_i.mem[32'h1068] = 32'h7;
      txq_host_mem_i.mem[32'h1074] = 32'h4005_0010;
      txq_host_mem_i.mem[32'h1078] = {16'($urandom), 16'h0008};
      txq_host_mem_i.mem[32'h1084] = 32'h2005_0010;
      reg_wr_t(A_IDX0 + 6'(4 * I_RW), 32'h3);
      settle();
      `CHK(txq_host_mem_i.mem[32'h106C], 32'h0000_8007)
      `CHK(txq_host_mem_i.mem[32'h107C], 32'h0000_8008)
      reg_wr_t(A_CTL, 32'h7);
      settle();
      exp_q.push_back({8'hA5, 6'h0, 1'b0, ST_BAD, 15'd5});
      `CHK(txq_host_mem_i.mem[32'h804C], exp_q[3])
      reg_rd_t(A_IDX0 + 6'(4 * I_FW), rd);
      `CHK(rd, 32'd20)
      $display("test chain done");
      end_sim();
   end
endmodule
